// *** llcr_host.sv ***
/*
 llcr_host: behavioural cpu on the parallel port, whole-word tasks.
 assumes: driven by the bench; strobes change on the falling edge only.
*/
`timescale 1ns/10ps
module llcr_host (
	// clock and width
	input wire clk_i,
	input wire b16_i,
	// device answers
	input wire wait_n_i,
	input wire data_oe_n_i,
	input wire [15:0] rdata_i,
	// cpu lines
	output reg cs_n_o,
	output reg wr_n_o,
	output reg rd_n_o,
	output reg [6:0] addr_o,
	output reg [15:0] data_o
);
	// counted here, compared by the bench at the end
	int stalls = 0;
	int oe_bad = 0;
	initial begin
		{cs_n_o, wr_n_o, rd_n_o} = 3'h7;
		addr_o = 7'h00;
		data_o = 16'h0000;
	end
	// one strobe; held until wait is seen low or 20 clocks pass, spacing kept after release
	task automatic acc(input bit w, input logic [6:0] a, input logic [15:0] d,
		output logic [15:0] q);
		int n;
		@(negedge clk_i);
		addr_o = a;
		data_o = d;
		{cs_n_o, wr_n_o, rd_n_o} = {1'b0, !w, w};
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (wait_n_i !== 1'b0 && n < 20);
		if (wait_n_i !== 1'b0)
			stalls++;
		// data lines driven only while a read is answered
		if (data_oe_n_i !== w)
			oe_bad++;
		q = rdata_i;
		@(negedge clk_i);
		{cs_n_o, wr_n_o, rd_n_o} = 3'h7;
		// released lines must not look like the last value
		data_o = ~data_o;
		repeat (5) @(negedge clk_i);
	endtask
	task automatic wr32(input logic [6:0] a, input logic [31:0] v);
		logic [15:0] q;
		for (int i = 0; i < (b16_i ? 2 : 4); i++)
			acc(1, a, b16_i ? v[16*i +: 16] : {8'h00, v[8*i +: 8]}, q);
	endtask
	task automatic rd32(input logic [6:0] a, output logic [31:0] v);
		logic [15:0] q;
		for (int i = 0; i < (b16_i ? 2 : 4); i++) begin
			acc(0, a, 16'h0000, q);
			if (b16_i)
				v[16*i +: 16] = q;
			else
				v[8*i +: 8] = q[7:0];
		end
	endtask
endmodule // llcr_host

// *** llcr_lane.v ***
/*
 llcr_lane: folds 8 or 16 bit cpu cycles into 32-bit register accesses.
 assumes: inputs already synchronised; the cpu repeats one address 2 or 4 times,
 low part first, and holds address and data while its strobe is low.
*/
`timescale 1ns/10ps
module llcr_lane (
	// clock and reset
	input wire clk_i,
	input wire resetn_i,
	// synchronised cpu pins
	input wire cs_n_i,
	input wire wr_n_i,
	input wire rd_n_i,
	input wire bus16_i,
	input wire [6:0] addr_i,
	input wire [15:0] din_i,
	// register side
	input wire [31:0] rdata_i,
	output reg wr_o,
	output reg [6:0] waddr_o,
	output reg [31:0] wdata_o,
	// cpu outputs
	output reg [15:0] dout_o,
	output reg dout_oe_n_o,
	output reg wait_n_o
);
	reg strobe_q;
	reg [1:0] lane_q;
	reg [6:0] last_addr_q;
	reg [31:0] shadow_q;
	reg [31:0] rsnap_q;
	wire strobe;
	wire start;
	wire [1:0] lane;
	wire last;
	wire [31:0] rword;

	// ----------------------------------------
	// lane select
	// ----------------------------------------
	function [15:0] lane_pick;
		input [31:0] w;
		input [1:0] l;
		input b16;
		begin
			if (b16)
				lane_pick = l[0] ? w[31:16] : w[15:0];
			else
				lane_pick = {8'h00, w[8*l +: 8]};
		end
	endfunction

	assign strobe = !cs_n_i && (!wr_n_i || !rd_n_i);
	assign start = strobe && !strobe_q;
	// a new address restarts the word; a lost lane cannot wedge the port
	assign lane = (addr_i == last_addr_q) ? lane_q : 2'd0;
	assign last = bus16_i ? lane[0] : (lane == 2'd3);
	assign rword = (lane == 2'd0) ? rdata_i : rsnap_q;

	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			strobe_q <= 1'b0;
			lane_q <= 2'd0;
			last_addr_q <= 7'h00;
			shadow_q <= 32'h0000_0000;
			rsnap_q <= 32'h0000_0000;
			wr_o <= 1'b0;
			waddr_o <= 7'h00;
			wdata_o <= 32'h0000_0000;
			dout_o <= 16'h0000;
			dout_oe_n_o <= 1'b1;
			wait_n_o <= 1'b1;
		end else begin
			strobe_q <= strobe;
			wr_o <= 1'b0;
			wait_n_o <= !(strobe && strobe_q);
			dout_oe_n_o <= !(!cs_n_i && !rd_n_i);
			if (start) begin
				last_addr_q <= addr_i;
				lane_q <= last ? 2'd0 : lane + 2'd1;
				if (!wr_n_i) begin
					if (bus16_i)
						shadow_q[16*lane[0] +: 16] <= din_i;
					else
						shadow_q[8*lane +: 8] <= din_i[7:0];
					if (last) begin
						wr_o <= 1'b1;
						waddr_o <= addr_i;
						if (bus16_i)
							wdata_o <= {din_i, shadow_q[15:0]};
						else
							wdata_o <= {din_i[7:0], shadow_q[23:0]};
					end
				end else begin
					// the word is captured once so a read sees one coherent value
					if (lane == 2'd0)
						rsnap_q <= rdata_i;
					dout_o <= lane_pick(rword, lane, bus16_i);
				end
			end
		end
	end
endmodule // llcr_lane

// *** llcr_map.vh ***
/*
 llcr_map.vh: offsets, field positions, reset values of the link config bank.
 assumes: included by bare name from the llcr design files.
*/
`ifndef LLCR_MAP_VH
`define LLCR_MAP_VH
// ----------------------------------------
// register offsets (cpu byte address)
// ----------------------------------------
`define LLCR_OFS_IDENT 7'h00
`define LLCR_OFS_NODE 7'h04
`define LLCR_OFS_CTRL 7'h08
// ----------------------------------------
// reset values and broadcast address
// ----------------------------------------
`define LLCR_NODE_RST 32'hffff_0000
`define LLCR_CTRL_RST 32'hc600_2a01
`define LLCR_BCAST_BUS 10'h3ff
`define LLCR_BCAST_NODE 6'h3f
// ----------------------------------------
// node address word fields
// ----------------------------------------
`define LLCR_N_BUS_HI 31
`define LLCR_N_BUS_LO 22
`define LLCR_N_NODE_HI 21
`define LLCR_N_NODE_LO 16
`define LLCR_N_ROOT 15
`define LLCR_N_POWER 14
`define LLCR_N_IS_CYCLE_MASTER 13
`define LLCR_N_COUNT_HI 11
`define LLCR_N_COUNT_LO 6
`define LLCR_N_CONT_HI 5
`define LLCR_N_CONT_LO 0
// ----------------------------------------
// control word fields
// ----------------------------------------
`define LLCR_C_OWNADDR 31
`define LLCR_C_SIDRX 30
`define LLCR_C_BUSY_HI 29
`define LLCR_C_BUSY_LO 27
`define LLCR_C_TXON 26
`define LLCR_C_RXON 25
`define LLCR_C_TXRST 21
`define LLCR_C_RXRST 20
`define LLCR_C_WIDTH 13
`define LLCR_C_ACK 12
`define LLCR_C_CMALLOW 11
`define LLCR_C_CYCLE_SOURCE_SELECT 10
`define LLCR_C_CYCNT 9
`define LLCR_C_SIDSTORE 3
`define LLCR_C_LPS 0
// ----------------------------------------
// acknowledge codes for write requests
// ----------------------------------------
`define LLCR_ACK_COMPLETE 2'h1
`define LLCR_ACK_PENDING 2'h2
`endif

// *** llcr_regs.v ***
/*
 llcr_regs: configuration register bank of the link layer controller:
 identity word, node address/status word and control word behind the cpu port.
 assumes: cpu pins are asynchronous; link-side status inputs and request inputs
 come from link logic on clk_i.
*/
`timescale 1ns/10ps
`include "llcr_map.vh"

module llcr_regs #(
	parameter [15:0] VERSION_CODE = 16'h0001, // arbitrary value
	parameter [15:0] REVISION_CODE = 16'h0000 // arbitrary value
) (
	// clock and reset
	input wire clk_i,
	input wire resetn_i,
	// cpu port pins
	input wire cpu_cs_n_i,
	input wire cpu_wr_n_i,
	input wire cpu_rd_n_i,
	input wire cpu_bus16_i,
	input wire [6:0] cpu_addr_i,
	input wire [15:0] cpu_data_i,
	output wire [15:0] cpu_data_o,
	output wire cpu_data_oe_n_o,
	output wire cpu_wait_n_o,
	// link status inputs
	input wire diagnostic_write_unlock_i,
	input wire status_load_i,
	input wire [5:0] node_number_i,
	input wire is_root_i,
	input wire cable_power_i,
	input wire is_cycle_master_i,
	input wire selfid_done_flag_i,
	input wire selfid_error_i,
	input wire [5:0] node_count_i,
	input wire [5:0] contender_phy_id_i,
	input wire can_contend_i,
	input wire [5:0] own_phy_id_i,
	// receiver and transmitter requests
	input wire dest_valid_i,
	input wire [9:0] dest_bus_i,
	input wire [5:0] dest_node_i,
	input wire write_req_i,
	input wire tx_request_i,
	// control outputs
	output reg rx_accept_o,
	output reg [1:0] write_ack_code_o,
	output reg tx_grant_o,
	output reg contender_is_self_o,
	output reg own_address_accept_o,
	output reg selfid_receive_enable_o,
	output reg [2:0] busy_policy_o,
	output reg transmitter_on_o,
	output reg receiver_on_o,
	output reg transmitter_soft_reset_o,
	output reg receiver_soft_reset_o,
	output reg transport_width_select_o,
	output reg cycle_master_run_o,
	output reg cycle_source_select_o,
	output reg cycle_offset_count_on_o,
	output reg selfid_store_o,
	output reg link_power_pin_o
);
	// ----------------------------------------
	// cpu pin crossing and lane folding
	// ----------------------------------------
	wire [26:0] pins_s;
	wire s_cs_n;
	wire s_wr_n;
	wire s_rd_n;
	wire s_bus16;
	wire [6:0] s_addr;
	wire [15:0] s_din;
	wire wr;
	wire [6:0] waddr;
	wire [31:0] wdata;
	reg [31:0] rdata;

	llcr_sync #(
		.W(27),
		.RST({3'b111, 24'h00_0000})
	) u_sync (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.d_i({cpu_cs_n_i, cpu_wr_n_i, cpu_rd_n_i, cpu_bus16_i, cpu_addr_i, cpu_data_i}),
		.q_o(pins_s)
	);

	assign {s_cs_n, s_wr_n, s_rd_n, s_bus16, s_addr, s_din} = pins_s;

	llcr_lane u_lane (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.cs_n_i(s_cs_n),
		.wr_n_i(s_wr_n),
		.rd_n_i(s_rd_n),
		.bus16_i(s_bus16),
		.addr_i(s_addr),
		.din_i(s_din),
		.rdata_i(rdata),
		.wr_o(wr),
		.waddr_o(waddr),
		.wdata_o(wdata),
		.dout_o(cpu_data_o),
		.dout_oe_n_o(cpu_data_oe_n_o),
		.wait_n_o(cpu_wait_n_o)
	);

	// ----------------------------------------
	// address decode
	// ----------------------------------------
	function hit;
		input [6:0] a;
		input [6:0] ofs;
		begin
			hit = (a == ofs);
		end
	endfunction

	wire wr_node = wr && hit(waddr, `LLCR_OFS_NODE);
	wire wr_ctrl = wr && hit(waddr, `LLCR_OFS_CTRL);

	// ----------------------------------------
	// node address/status word
	// ----------------------------------------
	reg [9:0] bus_number_q;
	reg [5:0] node_number_q;
	reg root_q;
	reg power_q;
	reg is_cycle_master_q;
	reg [5:0] node_count_q;
	reg [5:0] contender_q;
	reg done_q;
	wire done_rise = selfid_done_flag_i && !done_q;
	wire unlock_wr = wr_node && diagnostic_write_unlock_i;
	localparam [31:0] node_rst = `LLCR_NODE_RST;

	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			bus_number_q <= node_rst[`LLCR_N_BUS_HI:`LLCR_N_BUS_LO];
			node_number_q <= node_rst[`LLCR_N_NODE_HI:`LLCR_N_NODE_LO];
			root_q <= 1'b0;
			power_q <= 1'b0;
			is_cycle_master_q <= 1'b0;
			node_count_q <= 6'h00;
			contender_q <= 6'h00;
			done_q <= 1'b0;
		end else begin
			done_q <= selfid_done_flag_i;
			if (wr_node)
				bus_number_q <= wdata[`LLCR_N_BUS_HI:`LLCR_N_BUS_LO];
			// hardware updates take priority over a diagnostic write
			if (status_load_i) begin
				node_number_q <= node_number_i;
				root_q <= is_root_i;
				power_q <= cable_power_i;
				is_cycle_master_q <= is_cycle_master_i;
			end else if (unlock_wr) begin
				node_number_q <= wdata[`LLCR_N_NODE_HI:`LLCR_N_NODE_LO];
				root_q <= wdata[`LLCR_N_ROOT];
				power_q <= wdata[`LLCR_N_POWER];
				is_cycle_master_q <= wdata[`LLCR_N_IS_CYCLE_MASTER];
			end
			if (selfid_error_i)
				node_count_q <= 6'h00;
			else if (done_rise)
				node_count_q <= node_count_i;
			else if (unlock_wr)
				node_count_q <= wdata[`LLCR_N_COUNT_HI:`LLCR_N_COUNT_LO];
			if (done_rise)
				contender_q <= contender_phy_id_i;
			else if (unlock_wr)
				contender_q <= wdata[`LLCR_N_CONT_HI:`LLCR_N_CONT_LO];
		end
	end

	// ----------------------------------------
	// control word
	// ----------------------------------------
	reg own_accept_q;
	reg tx_on_q;
	reg rx_on_q;
	reg width_q;
	reg ack_q;
	reg cm_allow_q;
	reg sid_store_q;
	reg lps_q;
	localparam [31:0] ctrl_rst = `LLCR_CTRL_RST;

	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			own_accept_q <= ctrl_rst[`LLCR_C_OWNADDR];
			tx_on_q <= ctrl_rst[`LLCR_C_TXON];
			rx_on_q <= ctrl_rst[`LLCR_C_RXON];
			width_q <= ctrl_rst[`LLCR_C_WIDTH];
			ack_q <= ctrl_rst[`LLCR_C_ACK];
			cm_allow_q <= ctrl_rst[`LLCR_C_CMALLOW];
			sid_store_q <= ctrl_rst[`LLCR_C_SIDSTORE];
			lps_q <= ctrl_rst[`LLCR_C_LPS];
		end else if (wr_ctrl) begin
			// fixed fields 30, 29:27, 10 and 9 are not stored at all
			own_accept_q <= wdata[`LLCR_C_OWNADDR];
			tx_on_q <= wdata[`LLCR_C_TXON];
			rx_on_q <= wdata[`LLCR_C_RXON];
			width_q <= wdata[`LLCR_C_WIDTH];
			ack_q <= wdata[`LLCR_C_ACK];
			cm_allow_q <= wdata[`LLCR_C_CMALLOW];
			sid_store_q <= wdata[`LLCR_C_SIDSTORE];
			lps_q <= wdata[`LLCR_C_LPS];
		end
	end

	// ----------------------------------------
	// read data
	// ----------------------------------------
	always @* begin
		rdata = 32'h0000_0000;
		if (hit(s_addr, `LLCR_OFS_IDENT))
			rdata = {VERSION_CODE, REVISION_CODE};
		else if (hit(s_addr, `LLCR_OFS_NODE)) begin
			rdata[`LLCR_N_BUS_HI:`LLCR_N_BUS_LO] = bus_number_q;
			rdata[`LLCR_N_NODE_HI:`LLCR_N_NODE_LO] = node_number_q;
			rdata[`LLCR_N_ROOT] = root_q;
			rdata[`LLCR_N_POWER] = power_q;
			rdata[`LLCR_N_IS_CYCLE_MASTER] = is_cycle_master_q;
			rdata[`LLCR_N_COUNT_HI:`LLCR_N_COUNT_LO] = node_count_q;
			rdata[`LLCR_N_CONT_HI:`LLCR_N_CONT_LO] = contender_q;
		end else if (hit(s_addr, `LLCR_OFS_CTRL)) begin
			rdata[`LLCR_C_OWNADDR] = own_accept_q;
			rdata[`LLCR_C_SIDRX] = 1'b1;
			rdata[`LLCR_C_TXON] = tx_on_q;
			rdata[`LLCR_C_RXON] = rx_on_q;
			rdata[`LLCR_C_WIDTH] = width_q;
			rdata[`LLCR_C_ACK] = ack_q;
			rdata[`LLCR_C_CMALLOW] = cm_allow_q;
			rdata[`LLCR_C_CYCNT] = 1'b1;
			rdata[`LLCR_C_SIDSTORE] = sid_store_q;
			rdata[`LLCR_C_LPS] = lps_q;
		end
	end

	// ----------------------------------------
	// outputs to link logic
	// ----------------------------------------
	wire bcast = (dest_bus_i == `LLCR_BCAST_BUS) && (dest_node_i == `LLCR_BCAST_NODE);
	wire own = (dest_bus_i == bus_number_q) && (dest_node_i == node_number_q);
	wire soft_tx = wr_ctrl && wdata[`LLCR_C_TXRST];
	wire soft_rx = wr_ctrl && wdata[`LLCR_C_RXRST];

	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rx_accept_o <= 1'b0;
			write_ack_code_o <= `LLCR_ACK_COMPLETE;
			tx_grant_o <= 1'b0;
			contender_is_self_o <= 1'b0;
			own_address_accept_o <= 1'b0;
			selfid_receive_enable_o <= 1'b1;
			busy_policy_o <= 3'h0;
			transmitter_on_o <= 1'b0;
			receiver_on_o <= 1'b0;
			transmitter_soft_reset_o <= 1'b0;
			receiver_soft_reset_o <= 1'b0;
			transport_width_select_o <= 1'b0;
			cycle_master_run_o <= 1'b0;
			cycle_source_select_o <= 1'b0;
			cycle_offset_count_on_o <= 1'b1;
			selfid_store_o <= 1'b0;
			link_power_pin_o <= 1'b0;
		end else begin
			// gates follow the same registered enables that the link logic sees
			rx_accept_o <= dest_valid_i && receiver_on_o && !receiver_soft_reset_o &&
				(bcast || (own_address_accept_o && own));
			if (write_req_i)
				write_ack_code_o <= ack_q ? `LLCR_ACK_PENDING : `LLCR_ACK_COMPLETE;
			tx_grant_o <= tx_request_i && transmitter_on_o && !transmitter_soft_reset_o;
			contender_is_self_o <= can_contend_i && (own_phy_id_i > contender_q);
			own_address_accept_o <= own_accept_q;
			selfid_receive_enable_o <= 1'b1;
			busy_policy_o <= 3'h0;
			transmitter_on_o <= tx_on_q;
			receiver_on_o <= rx_on_q;
			transmitter_soft_reset_o <= soft_tx;
			receiver_soft_reset_o <= soft_rx;
			transport_width_select_o <= width_q;
			cycle_master_run_o <= cm_allow_q && root_q;
			cycle_source_select_o <= 1'b0;
			cycle_offset_count_on_o <= 1'b1;
			selfid_store_o <= sid_store_q;
			link_power_pin_o <= lps_q;
		end
	end
endmodule // llcr_regs

// *** llcr_regs_chk.sv ***
/*
 llcr_regs_chk: concurrent checks on the link config bank outputs.
 assumes: bound into llcr_regs; one clock, async active-low reset.
*/
`timescale 1ns/10ps
module llcr_regs_chk (
	// clock and reset
	input wire clk_i,
	input wire resetn_i,
	// link requests
	input wire dest_valid_i,
	input wire [9:0] dest_bus_i,
	input wire [5:0] dest_node_i,
	input wire write_req_i,
	// control outputs
	input wire rx_accept_o,
	input wire [1:0] write_ack_code_o,
	input wire tx_grant_o,
	input wire selfid_receive_enable_o,
	input wire [2:0] busy_policy_o,
	input wire transmitter_on_o,
	input wire receiver_on_o,
	input wire transmitter_soft_reset_o,
	input wire receiver_soft_reset_o,
	input wire cycle_source_select_o,
	input wire cycle_offset_count_on_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	// ----
	// checks
	// ----
	chk_fixed_vals: assert property (
		selfid_receive_enable_o && busy_policy_o == 3'h0 && !cycle_source_select_o
		&& cycle_offset_count_on_o) else $error("fixed control output moved");
	chk_txrst_pulse: assert property (
		transmitter_soft_reset_o |=> !transmitter_soft_reset_o) else $error("tx reset held");
	chk_rxrst_pulse: assert property (
		receiver_soft_reset_o |=> !receiver_soft_reset_o) else $error("rx reset held");
	chk_tx_gate: assert property (
		!transmitter_on_o |=> !tx_grant_o) else $error("grant while transmitter off");
	chk_rx_off: assert property (
		!receiver_on_o |=> !rx_accept_o) else $error("accept while receiver off");
	chk_rx_idle: assert property (
		!dest_valid_i |=> !rx_accept_o) else $error("accept without packet");
	chk_rx_bcast: assert property (
		dest_valid_i && {dest_bus_i, dest_node_i} == 16'hffff && receiver_on_o
		&& !receiver_soft_reset_o |=> rx_accept_o) else $error("broadcast refused");
	chk_ack_code: assert property (
		write_req_i |=> write_ack_code_o == 2'h1 || write_ack_code_o == 2'h2)
		else $error("bad write ack code");
	chk_ack_hold: assert property (
		!write_req_i |=> $stable(write_ack_code_o)) else $error("ack code moved");
endmodule // llcr_regs_chk

bind llcr_regs llcr_regs_chk llcr_regs_chk_inst (.*);

// *** llcr_sync.v ***
/*
 llcr_sync: two flip-flop synchroniser for a bus of independent levels.
 assumes: each bit is a slow level; multi-bit values are held stable by the cpu.
*/
`timescale 1ns/10ps
module llcr_sync #(
	parameter W = 8,
	parameter [W-1:0] RST = {W{1'b0}}
) (
	// clock and reset
	input wire clk_i,
	input wire resetn_i,
	// levels
	input wire [W-1:0] d_i,
	output reg [W-1:0] q_o
);
	reg [W-1:0] meta_q;

	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			meta_q <= RST;
			q_o <= RST;
		end else begin
			meta_q <= d_i;
			q_o <= meta_q;
		end
	end
endmodule // llcr_sync

// *** tb_llcr_regs.sv ***
/*
 tb_llcr_regs: self-checking bench for the link config bank.
 assumes: llcr_host plays the cpu; link inputs driven on the falling edge.
*/
`timescale 1ns/10ps
module tb_llcr_regs;
	localparam logic [15:0] VER = 16'h0a5c; // arbitrary value
	localparam logic [15:0] REV = 16'h0003; // arbitrary value
	localparam logic [31:0] CW = 32'h8600_3809;
	localparam logic [31:0] CF = 32'h4000_0200;
	logic clk_i = 0, resetn_i = 0, cpu_bus16_i = 1;
	logic cpu_cs_n_i, cpu_wr_n_i, cpu_rd_n_i, cpu_data_oe_n_o, cpu_wait_n_o;
	logic [6:0] cpu_addr_i;
	logic [15:0] cpu_data_i, cpu_data_o;
	logic diagnostic_write_unlock_i = 0, status_load_i = 0, is_root_i = 0, cable_power_i = 0;
	logic is_cycle_master_i = 0, selfid_done_flag_i = 0, selfid_error_i = 0, can_contend_i = 0;
	logic dest_valid_i = 0, write_req_i = 0, tx_request_i = 0;
	logic [5:0] node_number_i = 0, node_count_i = 0, contender_phy_id_i = 0, own_phy_id_i = 0;
	logic [9:0] dest_bus_i = 0;
	logic [5:0] dest_node_i = 0;
	logic rx_accept_o, tx_grant_o, contender_is_self_o, own_address_accept_o;
	logic selfid_receive_enable_o, transmitter_on_o, receiver_on_o, transmitter_soft_reset_o;
	logic receiver_soft_reset_o, transport_width_select_o, cycle_master_run_o;
	logic cycle_source_select_o, cycle_offset_count_on_o, selfid_store_o, link_power_pin_o;
	logic [1:0] write_ack_code_o;
	logic [2:0] busy_policy_o;
	logic [31:0] r, v, ctl;
	logic [9:0] bus;
	logic [5:0] nodenum, cnt, cont;
	logic root, pwr, cym;
	int bad_count = 0, check_count = 0, txp, rxp, seed;
	llcr_regs #(.VERSION_CODE(VER), .REVISION_CODE(REV)) llcr_regs_inst (.*);
	llcr_host llcr_host_inst (.clk_i, .b16_i(cpu_bus16_i), .wait_n_i(cpu_wait_n_o),
		.data_oe_n_i(cpu_data_oe_n_o),
		.rdata_i(cpu_data_o), .cs_n_o(cpu_cs_n_i), .wr_n_o(cpu_wr_n_i),
		.rd_n_o(cpu_rd_n_i), .addr_o(cpu_addr_i), .data_o(cpu_data_i));
	always #50 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		txp += transmitter_soft_reset_o;
		rxp += receiver_soft_reset_o;
	end
	// ----
	// checking and expectations
	// ----
	task chk(string n, logic [31:0] s, logic [31:0] e);
		check_count++;
		if (s !== e) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask
	function logic [31:0] nexp();
		return {bus, nodenum, root, pwr, cym, 1'b0, cnt, cont};
	endfunction
	function bit rx_exp(logic [9:0] b, logic [5:0] n);
		return ctl[25] && ({b, n} == 16'hffff || (ctl[31] && {b, n} == {bus, nodenum}));
	endfunction
	task outs;
		chk("own_acc", own_address_accept_o, ctl[31]);
		chk("sid_rx", selfid_receive_enable_o, 1);
		chk("busy", busy_policy_o, 0);
		chk("txon", transmitter_on_o, ctl[26]);
		chk("rxon", receiver_on_o, ctl[25]);
		chk("width", transport_width_select_o, ctl[13]);
		chk("cm_run", cycle_master_run_o, ctl[11] & root);
		chk("cycle_source_select", cycle_source_select_o, 0);
		chk("cycnt", cycle_offset_count_on_o, 1);
		chk("sid_store", selfid_store_o, ctl[3]);
		chk("lps", link_power_pin_o, ctl[0]);
		chk("self", contender_is_self_o, can_contend_i && own_phy_id_i > cont);
	endtask
	task traffic;
		for (int k = 0; k < 4; k++) begin
			dest_valid_i = 1;
			{dest_bus_i, dest_node_i} = k == 0 ? 16'hffff : k == 1 ? {bus, nodenum} : $urandom;
			write_req_i = 1;
			tx_request_i = k[0];
			@(negedge clk_i);
			{dest_valid_i, write_req_i} = 2'h0;
			chk("accept", rx_accept_o, rx_exp(dest_bus_i, dest_node_i));
			chk("ack", write_ack_code_o, ctl[12] ? 2 : 1);
			chk("grant", tx_grant_o, k[0] & ctl[26]);
		end
	endtask
	task close_out;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// ----
	// main sequence
	// ----
	initial begin
		seed = $urandom(32'hfdbf990d);
		{bus, nodenum, root, pwr, cym, cnt, cont} = 31'h7fff_8000;
		ctl = 32'hc600_2a01;
		repeat (8) @(negedge clk_i);
		resetn_i = 1;
		repeat (3) @(negedge clk_i);
		llcr_host_inst.rd32(7'h00, r);
		chk("ident", r, {VER, REV});
		llcr_host_inst.rd32(7'h08, r);
		chk("ctrl_rst", r, ctl);
		llcr_host_inst.wr32(7'h00, $urandom);
		llcr_host_inst.rd32(7'h00, r);
		chk("ident_ro", r, {VER, REV});
		llcr_host_inst.rd32(7'h0c, r);
		chk("unmapped", r, 0);
		v = $urandom;
		llcr_host_inst.wr32(7'h04, v);
		bus = v[31:22];
		llcr_host_inst.rd32(7'h04, r);
		chk("node_wr", r, nexp());
		{node_number_i, cable_power_i, is_cycle_master_i} = $urandom;
		is_root_i = 1;
		status_load_i = 1;
		@(negedge clk_i);
		status_load_i = 0;
		{nodenum, root, pwr, cym} = {node_number_i, is_root_i, cable_power_i, is_cycle_master_i};
		{node_count_i, contender_phy_id_i, own_phy_id_i} = $urandom;
		{can_contend_i, selfid_done_flag_i} = 2'h3;
		repeat (2) @(negedge clk_i);
		{cnt, cont} = {node_count_i, contender_phy_id_i};
		// the count must stay latched after the flag edge
		node_count_i = ~node_count_i;
		llcr_host_inst.rd32(7'h04, r);
		chk("node_ld", r, nexp());
		outs();
		selfid_error_i = 1;
		@(negedge clk_i);
		selfid_error_i = 0;
		cnt = 0;
		llcr_host_inst.rd32(7'h04, r);
		chk("node_err", r, nexp());
		diagnostic_write_unlock_i = 1;
		v = $urandom | 32'h0000_8000;
		llcr_host_inst.wr32(7'h04, v);
		diagnostic_write_unlock_i = 0;
		{bus, nodenum, root, pwr, cym} = v[31:13];
		{cnt, cont} = v[11:0];
		llcr_host_inst.rd32(7'h04, r);
		chk("node_unl", r, nexp());
		for (int i = 0; i < 6; i++) begin
			cpu_bus16_i = i != 2;
			v = i == 0 ? 32'hffff_ffff : i == 1 ? 32'h0000_0000 : $urandom;
			{txp, rxp} = 0;
			llcr_host_inst.wr32(7'h08, v);
			ctl = (v & CW) | CF;
			chk("tx_rst", txp, v[21]);
			chk("rx_rst", rxp, v[20]);
			llcr_host_inst.rd32(7'h08, r);
			chk("ctrl", r, ctl);
			outs();
			traffic();
		end
		chk("wait_stall", llcr_host_inst.stalls, 0);
		chk("data_oe", llcr_host_inst.oe_bad, 0);
		close_out();
	end
	initial begin
		repeat (20000) @(posedge clk_i);
		bad_count++;
		close_out();
	end
endmodule // tb_llcr_regs
